// file: common/mcsf_pkg.sv
package mcsf_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] SYS_STATUS_ADDR = 16'h00CA;
    localparam logic [ADDR_W-1:0] SYS_CONTROL_ADDR = 16'h0180;
    localparam logic [ADDR_W-1:0] STATUS_CLEAR_ADDR = 16'h019D;
    localparam logic [ADDR_W-1:0] SOFT_RESET_ADDR = 16'h01BF;
    localparam logic [DATA_W-1:0] SOFT_RESET_KEY = 32'h4572BEAF;

    // ----------------------------------------------------------------
    // Control word fields
    // ----------------------------------------------------------------
    localparam int ADC_RATE_LSB = 20;
    localparam int ADC_RATE_W = 2;
    localparam int METER_SEL_BIT = 19;
    localparam int BG_FINE_LSB = 16;
    localparam int BG_FINE_W = 3;
    localparam int BG_COARSE_LSB = 14;
    localparam int BG_COARSE_W = 2;
    localparam int TRIM_LSB = 7;
    localparam int TRIM_W = 5;
    localparam int SCALE_60HZ_BIT = 6;
    localparam int ADC_ENABLE_BIT = 0;
    localparam int FULL_FUNC_BIT = 1;
    localparam logic [DATA_W-1:0] SYS_CONTROL_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] SYS_CONTROL_MASK = 32'h003FCFC3;

    // ----------------------------------------------------------------
    // Status word fields
    // ----------------------------------------------------------------
    localparam int LIVE_LOW_BIT = 7;
    localparam int LATCHED_LOW_BIT = 6;
    localparam int RST_SRC_LSB = 3;
    localparam int RST_SRC_W = 3;
    localparam logic [RST_SRC_W-1:0] RST_SRC_RX = 3'h3;
    localparam logic [RST_SRC_W-1:0] RST_SRC_SOFT = 3'h4;

    // ----------------------------------------------------------------
    // Oscillator model and timing
    // ----------------------------------------------------------------
    localparam longint CLK_HZ = 125000000;
    localparam longint OSC_NOMINAL_HZ = 3276800;
    localparam longint OSC_BASE_INC = (OSC_NOMINAL_HZ << 32) / CLK_HZ;
    localparam int TRIM_STEP_PCT = 2;
    localparam int SCALE_60HZ_TENTHS = 12;
    localparam int SOFT_RESET_US = 650;
    localparam int CLK_MHZ = 125;
    localparam int SOFT_RESET_CYCLES = SOFT_RESET_US * CLK_MHZ;

    typedef enum logic {
        MCSF_RUN,
        MCSF_SOFT_RESET
    } mcsf_state_t;

endpackage

// file: rtl/mcsf_clock_divider.sv
`timescale 1ns/10ps
`default_nettype none
module mcsf_clock_divider (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Configuration
    input wire logic run_i,
    input wire logic [mcsf_pkg::TRIM_W-1:0] osc_trim_code_i,
    input wire logic osc_scale_60hz_i,
    input wire logic [mcsf_pkg::ADC_RATE_W-1:0] adc_rate_select_i,
    input wire logic meter_clock_select_i,
    // Tick outputs
    output logic meter_tick_o,
    output logic adc_tick_o
);
    import mcsf_pkg::*;

    logic [31:0] acc_ff, nxt_acc;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [32:0] sum;
    logic [31:0] inc;
    logic [4:0] adc_mask;
    logic tick;

    // ----------------------------------------------------------------
    // Oscillator frequency as a phase step
    // ----------------------------------------------------------------
    function automatic logic [31:0] osc_step(input logic [4:0] code,
                                            input logic scale);
        longint pct;
        longint tenths;
        longint step;
        pct = 100;
        if (code != 5'h00 && code[4] == 1'b0) begin
            pct = 100 - TRIM_STEP_PCT * longint'(code);
        end else if (code[4]) begin
            pct = 100 + TRIM_STEP_PCT * (32 - longint'(code));
        end
        tenths = scale ? SCALE_60HZ_TENTHS : 10;
        step = OSC_BASE_INC * pct * tenths / 1000;
        return step[31:0];
    endfunction

    always_comb begin
        inc = osc_step(osc_trim_code_i, osc_scale_60hz_i);
        sum = {1'b0, acc_ff} + {1'b0, inc};
        tick = run_i & sum[32];
        adc_mask = 5'((6'h04 << adc_rate_select_i) - 6'h01);
        nxt_acc = run_i ? sum[31:0] : 32'h00000000;
        nxt_cnt = !run_i ? 5'h00 : (tick ? cnt_ff + 5'h01 : cnt_ff);
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            acc_ff <= 32'h00000000;
            cnt_ff <= 5'h00;
        end else begin
            acc_ff <= nxt_acc;
            cnt_ff <= nxt_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Core and sampling ticks
    // ----------------------------------------------------------------
    always_comb begin
        meter_tick_o = meter_clock_select_i ?
            (tick & (cnt_ff[1:0] == 2'h3)) : tick;
        adc_tick_o = tick & ((cnt_ff & adc_mask) == adc_mask);
    end

endmodule
`default_nettype wire

// file: rtl/mcsf_top.sv
`timescale 1ns/10ps
`default_nettype none
module mcsf_top #(
    parameter int SOFT_RESET_CYCLES = mcsf_pkg::SOFT_RESET_CYCLES
) (
    // Clock and receive-line reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register port from the serial link
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [mcsf_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [mcsf_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [mcsf_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Supply monitor
    input wire logic supply_below_threshold_i,
    output logic supply_low_live_o,
    output logic supply_low_latched_o,
    output logic power_down_irq_o,
    // Clock configuration
    output logic [mcsf_pkg::ADC_RATE_W-1:0] adc_rate_select_o,
    output logic meter_clock_select_o,
    output logic [mcsf_pkg::TRIM_W-1:0] osc_trim_code_o,
    output logic osc_scale_60hz_o,
    output logic adc_sample_clock_o,
    output logic meter_core_clock_o,
    // Functional unit states
    output logic fast_osc_enable_o,
    output logic slow_osc_enable_o,
    output logic supply_monitor_enable_o,
    output logic serial_enable_o,
    output logic adc_enable_o,
    output logic meter_full_function_o,
    output logic in_reset_o
);
    import mcsf_pkg::*;

    localparam int CNT_W = $clog2(SOFT_RESET_CYCLES + 1);

    // ----------------------------------------------------------------
    // Control, status and sequencing state
    // ----------------------------------------------------------------
    mcsf_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
    logic [DATA_W-1:0] ctrl_ff, nxt_ctrl;
    logic [RST_SRC_W-1:0] rst_src_ff, nxt_rst_src;
    logic live_ff, nxt_live;
    logic latched_ff, nxt_latched;
    logic irq_ff, nxt_irq;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic meter_clk_ff, adc_clk_ff;
    logic run;
    logic wr_ctrl, wr_clear, wr_soft;
    logic meter_tick, adc_tick;

    always_comb begin
        run = (state_ff == MCSF_RUN);
        wr_ctrl = run & reg_wr_i & (reg_addr_i == SYS_CONTROL_ADDR);
        wr_clear = run & reg_wr_i & (reg_addr_i == STATUS_CLEAR_ADDR);
        wr_soft = run & reg_wr_i & (reg_addr_i == SOFT_RESET_ADDR)
            & (reg_wdata_i == SOFT_RESET_KEY);
    end

    // ----------------------------------------------------------------
    // Software reset sequencing and control word
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_rst_cnt = rst_cnt_ff;
        nxt_ctrl = ctrl_ff;
        nxt_rst_src = rst_src_ff;
        case (state_ff)
            MCSF_RUN: begin
                if (wr_soft) begin
                    nxt_state = MCSF_SOFT_RESET;
                    nxt_rst_cnt = CNT_W'(SOFT_RESET_CYCLES - 1);
                    nxt_ctrl = SYS_CONTROL_RESET;
                    nxt_rst_src = RST_SRC_SOFT;
                end else if (wr_ctrl) begin
                    nxt_ctrl = reg_wdata_i & SYS_CONTROL_MASK;
                end
            end
            MCSF_SOFT_RESET: begin
                nxt_ctrl = SYS_CONTROL_RESET;
                if (rst_cnt_ff == '0) begin
                    nxt_state = MCSF_RUN;
                end else begin
                    nxt_rst_cnt = rst_cnt_ff - CNT_W'(1);
                end
            end
            default: begin
                nxt_state = MCSF_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_ff <= MCSF_RUN;
            rst_cnt_ff <= '0;
            ctrl_ff <= SYS_CONTROL_RESET;
            rst_src_ff <= RST_SRC_RX;
        end else begin
            state_ff <= nxt_state;
            rst_cnt_ff <= nxt_rst_cnt;
            ctrl_ff <= nxt_ctrl;
            rst_src_ff <= nxt_rst_src;
        end
    end

    // ----------------------------------------------------------------
    // Supply power-down flags
    // ----------------------------------------------------------------
    always_comb begin
        nxt_live = supply_below_threshold_i;
        nxt_irq = supply_below_threshold_i & ~live_ff;
        nxt_latched = latched_ff;
        if (wr_clear && reg_wdata_i[LATCHED_LOW_BIT]) begin
            nxt_latched = 1'b0;
        end
        if (supply_below_threshold_i) begin
            nxt_latched = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            live_ff <= 1'b0;
            latched_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            live_ff <= nxt_live;
            latched_ff <= nxt_latched;
            irq_ff <= nxt_irq;
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    always_comb begin
        nxt_rvalid = reg_rd_i;
        nxt_rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                SYS_CONTROL_ADDR: begin
                    nxt_rdata = ctrl_ff;
                end
                SYS_STATUS_ADDR: begin
                    nxt_rdata[LIVE_LOW_BIT] = live_ff;
                    nxt_rdata[LATCHED_LOW_BIT] = latched_ff;
                    nxt_rdata[RST_SRC_LSB +: RST_SRC_W] = rst_src_ff;
                end
                default: begin
                    nxt_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // ----------------------------------------------------------------
    // Clock ticks
    // ----------------------------------------------------------------
    mcsf_clock_divider u_mcsf_clock_divider (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .run_i(run),
        .osc_trim_code_i(ctrl_ff[TRIM_LSB +: TRIM_W]),
        .osc_scale_60hz_i(ctrl_ff[SCALE_60HZ_BIT]),
        .adc_rate_select_i(ctrl_ff[ADC_RATE_LSB +: ADC_RATE_W]),
        .meter_clock_select_i(ctrl_ff[METER_SEL_BIT]),
        .meter_tick_o(meter_tick),
        .adc_tick_o(adc_tick)
    );

    // ADC ticks only while the converters are on
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            meter_clk_ff <= 1'b0;
            adc_clk_ff <= 1'b0;
        end else begin
            meter_clk_ff <= meter_tick;
            adc_clk_ff <= adc_tick & ctrl_ff[ADC_ENABLE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        reg_rdata_o = rdata_ff;
        reg_rvalid_o = rvalid_ff;
        supply_low_live_o = live_ff;
        supply_low_latched_o = latched_ff;
        power_down_irq_o = irq_ff;
        adc_rate_select_o = ctrl_ff[ADC_RATE_LSB +: ADC_RATE_W];
        meter_clock_select_o = ctrl_ff[METER_SEL_BIT];
        osc_trim_code_o = ctrl_ff[TRIM_LSB +: TRIM_W];
        osc_scale_60hz_o = ctrl_ff[SCALE_60HZ_BIT];
        adc_sample_clock_o = adc_clk_ff;
        meter_core_clock_o = meter_clk_ff;
        fast_osc_enable_o = 1'b1;
        slow_osc_enable_o = 1'b1;
        supply_monitor_enable_o = 1'b1;
        serial_enable_o = (state_ff == MCSF_RUN);
        adc_enable_o = ctrl_ff[ADC_ENABLE_BIT];
        meter_full_function_o = ctrl_ff[FULL_FUNC_BIT];
        in_reset_o = (state_ff == MCSF_SOFT_RESET);
    end

endmodule
`default_nettype wire

// file: testbench/mcsf_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module mcsf_assertions (
    // Clock, reset and register port
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic reg_wr_i,
    input wire logic [mcsf_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [mcsf_pkg::DATA_W-1:0] reg_wdata_i,
    // Supply flags
    input wire logic supply_below_threshold_i,
    input wire logic supply_low_live_o,
    input wire logic supply_low_latched_o,
    input wire logic power_down_irq_o,
    // Configuration and unit states
    input wire logic [mcsf_pkg::ADC_RATE_W-1:0] adc_rate_select_o,
    input wire logic meter_clock_select_o,
    input wire logic [mcsf_pkg::TRIM_W-1:0] osc_trim_code_o,
    input wire logic osc_scale_60hz_o,
    input wire logic fast_osc_enable_o,
    input wire logic slow_osc_enable_o,
    input wire logic supply_monitor_enable_o,
    input wire logic serial_enable_o,
    input wire logic adc_enable_o,
    input wire logic in_reset_o
);
    import mcsf_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic ctl_wr, clr_wr, key_wr;
    logic [DATA_W-1:0] wd_q;
    assign ctl_wr = reg_wr_i && !in_reset_o && reg_addr_i == SYS_CONTROL_ADDR;
    assign clr_wr = reg_wr_i && !in_reset_o && reg_addr_i == STATUS_CLEAR_ADDR
        && reg_wdata_i[LATCHED_LOW_BIT];
    assign key_wr = reg_wr_i && !in_reset_o && reg_addr_i == SOFT_RESET_ADDR
        && reg_wdata_i == SOFT_RESET_KEY;
    always_ff @(posedge clk_i) begin
        wd_q <= reg_wdata_i;
    end
    property p_ctl_clk;
        ctl_wr |=> adc_rate_select_o == wd_q[21:20]
            && meter_clock_select_o == wd_q[19];
    endproperty
    property p_ctl_osc;
        ctl_wr |=> osc_trim_code_o == wd_q[11:7]
            && osc_scale_60hz_o == wd_q[6];
    endproperty
    property p_soft;
        key_wr |=> in_reset_o && !serial_enable_o && !adc_enable_o
            && adc_rate_select_o == 2'h0 && !meter_clock_select_o
            && osc_trim_code_o == 5'h00 && !osc_scale_60hz_o;
    endproperty
    property p_units;
        fast_osc_enable_o && slow_osc_enable_o && supply_monitor_enable_o
            && serial_enable_o != in_reset_o;
    endproperty
    property p_live_set;
        supply_below_threshold_i |=> supply_low_live_o && supply_low_latched_o;
    endproperty
    property p_live_clr;
        !supply_below_threshold_i |=> !supply_low_live_o;
    endproperty
    property p_irq;
        !supply_low_live_o && supply_below_threshold_i |=> power_down_irq_o;
    endproperty
    property p_irq_only;
        power_down_irq_o |-> supply_low_live_o && !$past(supply_low_live_o);
    endproperty
    property p_latch_hold;
        supply_low_latched_o && !clr_wr |=> supply_low_latched_o;
    endproperty
    property p_latch_clr;
        clr_wr && !supply_below_threshold_i |=> !supply_low_latched_o;
    endproperty
    a_ctl_clk: assert property (p_ctl_clk)
        else $error("clock fields");
    a_ctl_osc: assert property (p_ctl_osc)
        else $error("osc fields");
    a_soft: assert property (p_soft)
        else $error("soft reset state");
    a_units: assert property (p_units)
        else $error("unit enables");
    a_live_set: assert property (p_live_set)
        else $error("flag set");
    a_live_clr: assert property (p_live_clr)
        else $error("live clear");
    a_irq: assert property (p_irq)
        else $error("irq missing");
    a_irq_only: assert property (p_irq_only)
        else $error("irq without rising supply low");
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch lost");
    a_latch_clr: assert property (p_latch_clr)
        else $error("latch stuck");
    c_soft: cover property (key_wr);
    c_clr: cover property (clr_wr && supply_low_latched_o);
    c_irq: cover property (power_down_irq_o);
endmodule
`default_nettype wire

// file: testbench/mcsf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mcsf_host_model (
    // Clock
    input wire logic clk_i,
    // Register port towards the device
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [mcsf_pkg::ADDR_W-1:0] reg_addr_o,
    output logic [mcsf_pkg::DATA_W-1:0] reg_wdata_o,
    input wire logic [mcsf_pkg::DATA_W-1:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    import mcsf_pkg::*;
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 16'h0000;
        reg_wdata_o = 32'h00000000;
    end
    // Released bus shows the inverse of the last value
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        reg_wr_o <= 1'b1;
        reg_addr_o <= a;
        reg_wdata_o <= d;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a,
                      output logic [DATA_W-1:0] d);
        int n;
        @(posedge clk_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= a;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        d = 'x;
        for (n = 0; n < 4; n++) begin
            @(posedge clk_i);
            if (reg_rvalid_i === 1'b1) begin
                d = reg_rdata_i;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: testbench/mcsf_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mcsf_bench;
    import mcsf_pkg::*;
    localparam int HOLD = 20;
    logic clk_i, reset_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, in_reset_o;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
    logic supply_below_threshold_i, supply_low_live_o, supply_low_latched_o;
    logic power_down_irq_o, meter_clock_select_o, osc_scale_60hz_o;
    logic adc_sample_clock_o, meter_core_clock_o, fast_osc_enable_o;
    logic slow_osc_enable_o, supply_monitor_enable_o, serial_enable_o;
    logic adc_enable_o, meter_full_function_o;
    logic [ADC_RATE_W-1:0] adc_rate_select_o;
    logic [TRIM_W-1:0] osc_trim_code_o;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    mcsf_top #(.SOFT_RESET_CYCLES(HOLD)) u_mcsf_top (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o),
        .supply_below_threshold_i(supply_below_threshold_i),
        .supply_low_live_o(supply_low_live_o),
        .supply_low_latched_o(supply_low_latched_o),
        .power_down_irq_o(power_down_irq_o),
        .adc_rate_select_o(adc_rate_select_o),
        .meter_clock_select_o(meter_clock_select_o),
        .osc_trim_code_o(osc_trim_code_o),
        .osc_scale_60hz_o(osc_scale_60hz_o),
        .adc_sample_clock_o(adc_sample_clock_o),
        .meter_core_clock_o(meter_core_clock_o),
        .fast_osc_enable_o(fast_osc_enable_o),
        .slow_osc_enable_o(slow_osc_enable_o),
        .supply_monitor_enable_o(supply_monitor_enable_o),
        .serial_enable_o(serial_enable_o),
        .adc_enable_o(adc_enable_o),
        .meter_full_function_o(meter_full_function_o),
        .in_reset_o(in_reset_o)
    );
    mcsf_host_model u_mcsf_host_model (
        .clk_i(clk_i),
        .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i),
        .reg_rdata_i(reg_rdata_o),
        .reg_rvalid_i(reg_rvalid_o)
    );
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [DATA_W-1:0] g,
                       input logic [DATA_W-1:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        u_mcsf_host_model.wr(a, d);
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] d;
        u_mcsf_host_model.rd(a, d);
        chk(d, e);
    endtask
    // Pulse counts over a window of 3815 cycles, one count of slack
    task automatic ticks(input logic [DATA_W-1:0] ctl,
                         input int em,
                         input int ea);
        int m;
        int a;
        m = 0;
        a = 0;
        wr(SYS_CONTROL_ADDR, ctl);
        repeat (8) @(posedge clk_i);
        repeat (3815) begin
            @(posedge clk_i);
            if (meter_core_clock_o === 1'b1) m++;
            if (adc_sample_clock_o === 1'b1) a++;
        end
        chk(32'((m >= em - 1 && m <= em + 1) ? em : m), 32'(em));
        chk(32'((a >= ea - 1 && a <= ea + 1) ? ea : a), 32'(ea));
    endtask
    initial begin
        reset_n_i = 1'b0;
        supply_below_threshold_i = 1'b0;
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rchk(SYS_CONTROL_ADDR, 32'h00000000);
        rchk(SYS_STATUS_ADDR, 32'h00000018);
        chk(32'({adc_enable_o, meter_full_function_o}), 32'h0);
        rchk(16'h0100, 32'h00000000);
        wr(SYS_CONTROL_ADDR, 32'hFFFFFFFF);
        rchk(SYS_CONTROL_ADDR, 32'h003FCFC3);
        ticks(32'h00000003, 100, 25);
        ticks(32'h00100001, 100, 12);
        ticks(32'h00280003, 25, 6);
        ticks(32'h00300001, 100, 3);
        ticks(32'h00000080, 98, 0);
        ticks(32'h00000780, 70, 0);
        ticks(32'h00000F80, 102, 0);
        ticks(32'h00000800, 132, 0);
        ticks(32'h00000040, 120, 0);
        ticks(32'h00000000, 100, 0);
        supply_below_threshold_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rchk(SYS_STATUS_ADDR, 32'h000000D8);
        wr(STATUS_CLEAR_ADDR, 32'h00000040);
        rchk(SYS_STATUS_ADDR, 32'h000000D8);
        supply_below_threshold_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rchk(SYS_STATUS_ADDR, 32'h00000058);
        wr(STATUS_CLEAR_ADDR, 32'h00000040);
        rchk(SYS_STATUS_ADDR, 32'h00000018);
        wr(SYS_CONTROL_ADDR, 32'h00000003);
        wr(SOFT_RESET_ADDR, SOFT_RESET_KEY ^ 32'h00000001);
        rchk(SYS_CONTROL_ADDR, 32'h00000003);
        wr(SOFT_RESET_ADDR, SOFT_RESET_KEY);
        wr(SYS_CONTROL_ADDR, 32'hFFFFFFFF);
        repeat (HOLD + 10) @(posedge clk_i);
        rchk(SYS_CONTROL_ADDR, 32'h00000000);
        rchk(SYS_STATUS_ADDR, 32'h00000020);
        wr(SYS_CONTROL_ADDR, 32'h00000003);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rchk(SYS_CONTROL_ADDR, 32'h00000000);
        rchk(SYS_STATUS_ADDR, 32'h00000018);
        end_sim();
    end
endmodule
bind mcsf_top mcsf_assertions u_mcsf_assertions (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .supply_below_threshold_i(supply_below_threshold_i),
    .supply_low_live_o(supply_low_live_o),
    .supply_low_latched_o(supply_low_latched_o),
    .power_down_irq_o(power_down_irq_o),
    .adc_rate_select_o(adc_rate_select_o),
    .meter_clock_select_o(meter_clock_select_o),
    .osc_trim_code_o(osc_trim_code_o),
    .osc_scale_60hz_o(osc_scale_60hz_o),
    .fast_osc_enable_o(fast_osc_enable_o),
    .slow_osc_enable_o(slow_osc_enable_o),
    .supply_monitor_enable_o(supply_monitor_enable_o),
    .serial_enable_o(serial_enable_o),
    .adc_enable_o(adc_enable_o),
    .in_reset_o(in_reset_o)
);
`default_nettype wire
